// *** include/rvq_pkg.sv ***
// Shared constants, types and decode functions of the ring validation qualifier
package rvq_pkg;

  // Register port geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [7:0] REG_CTRL2      = 8'h17;
  localparam logic [7:0] REG_CTRL3      = 8'h18;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h30;
  localparam logic [7:0] REG_IRQ_CLEAR  = 8'h31;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h32;
  localparam logic [7:0] REG_STATE      = 8'h33;

  // Values after reset, write mask of control three
  localparam logic [7:0] CTRL2_RESET   = 8'h2D;
  localparam logic [7:0] CTRL3_RESET   = 8'h19;
  localparam logic [7:0] CTRL3_WMASK   = 8'hBF;
  localparam logic [2:0] IRQ_EN_RESET  = 3'h0;

  // Field positions
  localparam int unsigned CONFIRM_LSB  = 0;
  localparam int unsigned CONFIRM_W    = 3;
  localparam int unsigned TIMEOUT_LSB  = 3;
  localparam int unsigned TIMEOUT_W    = 4;
  localparam int unsigned DELAY_HI_BIT = 7;
  localparam int unsigned RAS_LSB      = 0;
  localparam int unsigned RAS_W        = 6;
  localparam int unsigned RESERVED_BIT = 6;
  localparam int unsigned ENABLE_BIT   = 7;

  // Interrupt status layout
  localparam int unsigned IRQ_W       = 3;
  localparam int unsigned IRQ_VALID   = 0;
  localparam int unsigned IRQ_INVALID = 1;
  localparam int unsigned IRQ_END     = 2;

  // Time base
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TICK_TIME_NS  = 2_000_000;
  localparam int unsigned TICK_MS       = 2;
  localparam int unsigned TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

  // Timer figures in milliseconds
  localparam int unsigned PH_W = 10;
  localparam int unsigned CONFIRM_MS [8] = '{100, 150, 200, 256, 384, 512, 640, 1024};
  localparam int unsigned TIMEOUT_BASE_MS = 80;
  localparam int unsigned TIMEOUT_STEP_MS = 128;
  localparam int unsigned DELAY_STEP_MS   = 256;

  // Qualifier states
  typedef enum logic [1:0] {
    RVQ_IDLE  = 2'b00,
    RVQ_QUAL  = 2'b01,
    RVQ_DELAY = 2'b10,
    RVQ_VALID = 2'b11
  } rvq_state_t;

  // Confirmation code to ticks
  function automatic logic [PH_W-1:0] rvq_confirm_ticks(input logic [2:0] code);
    rvq_confirm_ticks = PH_W'(CONFIRM_MS[code] / TICK_MS);
  endfunction

  // Timeout code to ticks: code zero is the short special case
  function automatic logic [PH_W-1:0] rvq_timeout_ticks(input logic [3:0] code);
    int unsigned ms;
    ms = (code == 4'h0) ? TIMEOUT_BASE_MS : 32'(code) * TIMEOUT_STEP_MS;
    rvq_timeout_ticks = PH_W'(ms / TICK_MS);
  endfunction

  // Report delay code to ticks
  function automatic logic [PH_W-1:0] rvq_delay_ticks(input logic [2:0] code);
    rvq_delay_ticks = PH_W'((32'(code) * DELAY_STEP_MS) / TICK_MS);
  endfunction

endpackage

// *** include/rvq_tick_if.sv ***
// Common time base tick shared by the qualifier timers
`timescale 1ns/1ps
`default_nettype none
interface rvq_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface
`default_nettype wire

// *** logic/rvq_timebase.sv ***
// Prescaler that makes the nominal two millisecond tick
`timescale 1ns/1ps
`default_nettype none
module rvq_timebase #(
  parameter int unsigned TICK_CYCLES = rvq_pkg::TICK_CYCLES
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_b,
  input  wire logic i_run,
  rvq_tick_if.src   tb
);
  import rvq_pkg::*;
  localparam int unsigned CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          tick_reg;
  logic          tick_next;
  logic          wrap;

  // Restart phase when stopped so the first tick is a full period away
  always_comb begin
    wrap      = (cnt_reg == CW'(TICK_CYCLES - 1));
    cnt_next  = (!i_run || wrap) ? '0 : cnt_reg + 1'b1;
    tick_next = i_run && wrap;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tb.tick = tick_reg;

  AST_TICK_GAP: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (tb.tick && TICK_CYCLES > 1) |=> !tb.tick)
    else $error("tick pulses closer than one period");

endmodule
`default_nettype wire

// *** logic/rvq_down_timer.sv ***
// Loadable down counter stepped by the common tick
`timescale 1ns/1ps
`default_nettype none
module rvq_down_timer #(
  parameter int unsigned W = 6
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_b,
  rvq_tick_if.dst           tb,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_value,
  output var  logic [W-1:0] o_count
);
  logic [W-1:0] count_next;

  // Load wins over a tick; stops at zero instead of wrapping
  always_comb begin
    count_next = o_count;
    if (i_load) begin
      count_next = i_value;
    end else if (tb.tick && o_count != '0) begin
      count_next = o_count - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_count <= '0;
    end else begin
      o_count <= count_next;
    end
  end

  AST_TIMER_DEC: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (!i_load && tb.tick && o_count != '0) |=> (o_count == $past(o_count) - 1'b1))
    else $error("timer did not step down on tick");

endmodule
`default_nettype wire

// *** logic/rvq_ring_qualifier.sv ***
// Ring validation qualifier with register port and interrupt
//
// Function
// - Enable bit gates all validation.
// - First ring event loads interval timer with assertion time; timer counts down per tick.
// - Each later ring event before valid compares remaining interval time with minimum-interval field.
// - Remaining time above minimum-interval means frequency too high; ring invalidated.
// - Assertion time minus minimum-interval gives least event spacing, in 2 ms steps.
// - Assertion time field sets highest accepted ring frequency, within ten percent.
// - Events come twice per ring period; 20 Hz ringing gives 25 ms spacing.
// - Cadence must stay in range for selected confirmation time, 100 to 1024 ms.
// - Ring declared over after selected timeout since last crossing, 80 to 1920 ms.
// - Valid ring reported after selected delay, 0 to 1792 ms, 3-bit split code.
// - Reserved bit 6 of control three carries no meaning when read.
`timescale 1ns/1ps
`default_nettype none
module rvq_ring_qualifier #(
  parameter int unsigned TICK_CYCLES = rvq_pkg::TICK_CYCLES
) (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_rst_b,
  input  wire logic                        i_ring_event,
  input  wire logic [1:0]                  i_delay_lo,
  input  wire logic [rvq_pkg::RAS_W-1:0]   i_min_interval_threshold,
  input  wire logic [rvq_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [rvq_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output var  logic [rvq_pkg::DATA_W-1:0]  o_rdata,
  output var  logic                        o_ring_valid,
  output var  logic                        o_irq
);
  import rvq_pkg::*;

  // Configuration registers
  logic [DATA_W-1:0] ctrl2_reg;
  logic [DATA_W-1:0] ctrl2_next;
  logic [DATA_W-1:0] ctrl3_reg;
  logic [DATA_W-1:0] ctrl3_next;
  logic [IRQ_W-1:0]  irq_en_reg;
  logic [IRQ_W-1:0]  irq_en_next;

  // Interrupt and read path
  logic [IRQ_W-1:0]  irq_sts_reg;
  logic [IRQ_W-1:0]  irq_sts_next;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_clr;
  logic              irq_next;
  logic [DATA_W-1:0] rdata_next;

  // Event synchroniser
  logic [2:0]        sync_reg;
  logic [2:0]        sync_next;
  logic              ring_evt;

  // Qualifier state
  rvq_state_t        state_reg;
  rvq_state_t        state_next;
  logic              valid_next;

  // Timer controls
  logic              iv_load;
  logic              ph_load;
  logic              to_load;
  logic [PH_W-1:0]   ph_value;
  logic [RAS_W-1:0]  iv_count;
  logic [PH_W-1:0]   ph_count;
  logic [PH_W-1:0]   to_count;
  logic              too_fast;

  // Field views
  logic              val_enable;
  logic [RAS_W-1:0]  ring_assert_time;
  logic [2:0]        ring_confirm_time;
  logic [3:0]        ring_end_timeout;
  logic [2:0]        valid_ring_report_delay;

  // Decoded fields of the two control registers and the delay input pins
  always_comb begin
    val_enable              = ctrl3_reg[ENABLE_BIT];
    ring_assert_time        = ctrl3_reg[RAS_LSB +: RAS_W];
    ring_confirm_time       = ctrl2_reg[CONFIRM_LSB +: CONFIRM_W];
    ring_end_timeout        = ctrl2_reg[TIMEOUT_LSB +: TIMEOUT_W];
    valid_ring_report_delay = {ctrl2_reg[DELAY_HI_BIT], i_delay_lo};
  end

  // Register writes; reserved bit is never stored
  always_comb begin
    ctrl2_next  = ctrl2_reg;
    ctrl3_next  = ctrl3_reg;
    irq_en_next = irq_en_reg;
    irq_clr     = '0;
    if (i_wr) begin
      case (i_addr)
        REG_CTRL2: begin
          ctrl2_next = i_wdata;
        end
        REG_CTRL3: begin
          ctrl3_next = i_wdata & CTRL3_WMASK;
        end
        REG_IRQ_ENABLE: begin
          irq_en_next = i_wdata[IRQ_W-1:0];
        end
        REG_IRQ_CLEAR: begin
          irq_clr = i_wdata[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read data only in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_next = '0;
    if (i_rd) begin
      case (i_addr)
        REG_CTRL2: begin
          rdata_next = ctrl2_reg;
        end
        REG_CTRL3: begin
          rdata_next = ctrl3_reg & CTRL3_WMASK;
        end
        REG_IRQ_STATUS: begin
          rdata_next = {{(DATA_W - IRQ_W){1'b0}}, irq_sts_reg};
        end
        REG_IRQ_ENABLE: begin
          rdata_next = {{(DATA_W - IRQ_W){1'b0}}, irq_en_reg};
        end
        REG_STATE: begin
          rdata_next = {5'h00, o_ring_valid, state_reg};
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  // Two flops before use, third flop only for the edge
  always_comb begin
    sync_next = {sync_reg[1:0], i_ring_event};
    ring_evt  = sync_reg[1] & ~sync_reg[2];
  end

  // Shared tick and the three timers on it
  rvq_tick_if tick_bus ();

  rvq_timebase #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timebase (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_run     (val_enable),
    .tb        (tick_bus.src)
  );

  rvq_down_timer #(
    .W (RAS_W)
  ) u_interval (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .tb        (tick_bus.dst),
    .i_load    (iv_load),
    .i_value   (ring_assert_time),
    .o_count   (iv_count)
  );

  // Confirmation and report delay run one after the other on one counter
  rvq_down_timer #(
    .W (PH_W)
  ) u_phase (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .tb        (tick_bus.dst),
    .i_load    (ph_load),
    .i_value   (ph_value),
    .o_count   (ph_count)
  );

  rvq_down_timer #(
    .W (PH_W)
  ) u_timeout (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .tb        (tick_bus.dst),
    .i_load    (to_load),
    .i_value   (rvq_timeout_ticks(ring_end_timeout)),
    .o_count   (to_count)
  );

  // Qualifier sequence; a late event may still be too fast during the delay
  always_comb begin
    state_next = state_reg;
    iv_load    = 1'b0;
    ph_load    = 1'b0;
    to_load    = 1'b0;
    ph_value   = rvq_confirm_ticks(ring_confirm_time);
    irq_set    = '0;
    too_fast   = iv_count > i_min_interval_threshold;
    if (!val_enable) begin
      state_next = RVQ_IDLE;
    end else begin
      unique case (state_reg)
        RVQ_IDLE: begin
          if (ring_evt) begin
            iv_load    = 1'b1;
            ph_load    = 1'b1;
            to_load    = 1'b1;
            state_next = RVQ_QUAL;
          end
        end
        RVQ_QUAL, RVQ_DELAY: begin
          if (ring_evt && too_fast) begin
            state_next           = RVQ_IDLE;
            irq_set[IRQ_INVALID] = 1'b1;
          end else if (ring_evt) begin
            iv_load = 1'b1;
            to_load = 1'b1;
          end else if (to_count == '0) begin
            state_next = RVQ_IDLE;
          end
          if (!(ring_evt && too_fast) && (ring_evt || to_count != '0) && ph_count == '0) begin
            if (state_reg == RVQ_QUAL) begin
              ph_load    = 1'b1;
              ph_value   = rvq_delay_ticks(valid_ring_report_delay);
              state_next = RVQ_DELAY;
            end else begin
              state_next         = RVQ_VALID;
              irq_set[IRQ_VALID] = 1'b1;
            end
          end
        end
        RVQ_VALID: begin
          if (ring_evt) begin
            to_load = 1'b1;
          end else if (to_count == '0) begin
            state_next       = RVQ_IDLE;
            irq_set[IRQ_END] = 1'b1;
          end
        end
      endcase
    end
    valid_next = (state_next == RVQ_VALID);
  end

  // Sticky status: a new event beats a clear in the same cycle
  always_comb begin
    irq_sts_next = (irq_sts_reg & ~irq_clr) | irq_set;
    irq_next     = |(irq_sts_next & irq_en_next);
  end

  // All state registers of the block
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      ctrl2_reg    <= CTRL2_RESET;
      ctrl3_reg    <= CTRL3_RESET;
      irq_en_reg   <= IRQ_EN_RESET;
      irq_sts_reg  <= '0;
      o_irq        <= 1'b0;
      o_rdata      <= '0;
      sync_reg     <= 3'h0;
      state_reg    <= RVQ_IDLE;
      o_ring_valid <= 1'b0;
    end else begin
      ctrl2_reg    <= ctrl2_next;
      ctrl3_reg    <= ctrl3_next;
      irq_en_reg   <= irq_en_next;
      irq_sts_reg  <= irq_sts_next;
      o_irq        <= irq_next;
      o_rdata      <= rdata_next;
      sync_reg     <= sync_next;
      state_reg    <= state_next;
      o_ring_valid <= valid_next;
    end
  end

  // Checks on the qualifier
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  AST_DISABLED_IDLE: assert property (
    !val_enable |=> (state_reg == RVQ_IDLE) ##1 !o_ring_valid)
    else $error("qualifier active while disabled");

  AST_INTERVAL_LOAD: assert property (
    (val_enable && state_reg == RVQ_IDLE && ring_evt) |=> (iv_count == $past(ring_assert_time)))
    else $error("interval timer not loaded with assertion time");

  AST_TOO_FAST: assert property (
    (val_enable && state_reg inside {RVQ_QUAL, RVQ_DELAY} && ring_evt && iv_count > i_min_interval_threshold)
    |=> (state_reg == RVQ_IDLE) && irq_sts_reg[IRQ_INVALID])
    else $error("fast ring not invalidated");

  AST_SPACING_OK: assert property (
    (val_enable && ctrl3_next[ENABLE_BIT] && state_reg == RVQ_QUAL && ring_evt
     && iv_count <= i_min_interval_threshold) |=> (state_reg != RVQ_IDLE))
    else $error("slow enough event dropped qualification");

  AST_NO_VALID_ON_INVALID: assert property (
    (val_enable && state_reg == RVQ_QUAL && ring_evt && too_fast) |=> !o_ring_valid ##1 !o_ring_valid)
    else $error("valid reported after invalidation");

  AST_VALID_VIA_DELAY: assert property (
    $rose(o_ring_valid) |-> (state_reg == RVQ_VALID) && ($past(state_reg) == RVQ_DELAY))
    else $error("valid ring reported without delay phase");

  AST_RING_END: assert property (
    (val_enable && ctrl3_next[ENABLE_BIT] && state_reg == RVQ_VALID && !ring_evt && to_count == '0)
    |=> (state_reg == RVQ_IDLE) && !o_ring_valid && irq_sts_reg[IRQ_END])
    else $error("ring end not declared on timeout");

  AST_RESERVED_ZERO: assert property (
    (i_rd && i_addr == REG_CTRL3) |=> !o_rdata[RESERVED_BIT])
    else $error("reserved bit read as one");

  COV_VALID: cover property ($rose(o_ring_valid));
  COV_INVALID: cover property (state_reg == RVQ_DELAY && ring_evt && too_fast);
  COV_END: cover property ($fell(o_ring_valid) && val_enable);

endmodule
`default_nettype wire

// *** bench/rvq_ring_source.sv ***
// Ring detector model: raw threshold crossing events at a set spacing
`timescale 1ns/1ps
`default_nettype none
module rvq_ring_source (
  input  wire logic        i_sys_clk,
  input  wire logic        i_go,
  input  wire logic [15:0] i_gap,
  output var  logic        o_ring_event
);
  // Phase counter starts at zero; the line goes quiet at the first edge
  logic [15:0] cnt_reg = 16'h0000;

  // Two crossings per ring period; each held 4 clocks so the synchroniser sees it
  always @(posedge i_sys_clk) begin
    if (!i_go) begin
      cnt_reg <= 16'h0000;
      o_ring_event <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg + 16'h0001 >= i_gap) ? 16'h0000 : cnt_reg + 16'h0001;
      o_ring_event <= (cnt_reg < 16'h0004);
    end
  end
endmodule
`default_nettype wire

// *** bench/rvq_ring_qualifier_tb_top.sv ***
// Self-checking bench of the ring validation qualifier
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module rvq_ring_qualifier_tb_top;
  import rvq_pkg::*;
  localparam int TCK = 4;  // Clocks per tick, shortened from 2 ms
  localparam int TOL = 12; // Sync stages, state steps and tick phase
  logic        i_sys_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic [1:0]  i_delay_lo = 2'h0;
  logic [5:0]  i_min_interval_threshold = 6'h05;
  logic [7:0]  i_addr = 8'h00;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        go = 1'b0;
  logic [15:0] gap = 16'h0028;
  logic        ring_event;
  logic [7:0]  o_rdata;
  logic        o_ring_valid;
  logic        o_irq;
  logic [7:0]  rdv;
  logic [7:0]  mdl [256];
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          first_ev = 0;
  int          last_ev = 0;
  int          seed = 32'h772D75A4;
  int          conf_ms [8] = '{100, 150, 200, 256, 384, 512, 640, 1024};

  always #2 i_sys_clk = ~i_sys_clk;

  rvq_ring_source rvq_ring_source_i (
    .i_sys_clk    (i_sys_clk),
    .i_go         (go),
    .i_gap        (gap),
    .o_ring_event (ring_event)
  );

  rvq_ring_qualifier #(.TICK_CYCLES(TCK)) rvq_ring_qualifier_i (
    .i_sys_clk                (i_sys_clk),
    .i_rst_b                  (i_rst_b),
    .i_ring_event             (ring_event),
    .i_delay_lo               (i_delay_lo),
    .i_min_interval_threshold (i_min_interval_threshold),
    .i_addr                   (i_addr),
    .i_wdata                  (i_wdata),
    .i_wr                     (i_wr),
    .i_rd                     (i_rd),
    .o_rdata                  (o_rdata),
    .o_ring_valid             (o_ring_valid),
    .o_irq                    (o_irq)
  );

  // Cycle count and hang guard; the loop of all codes needs about 60k cycles
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      summarize();
    end
  end

  // Time of the latest crossing, for the timeout figure
  always @(posedge ring_event) last_ev = cyc;

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One write cycle, and the model follows it
  task automatic wm(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    case (a)
      REG_CTRL2: mdl[a] = d;
      REG_CTRL3: mdl[a] = d & 8'hBF;
      REG_IRQ_CLEAR: mdl[REG_IRQ_STATUS] = mdl[REG_IRQ_STATUS] & ~d;
      REG_IRQ_ENABLE: mdl[a] = d & 8'h07;
      default: ;
    endcase
  endtask

  // One read cycle; data stand only in the following cycle
  task automatic rc(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 rdv = o_rdata;
    `CHK($sformatf("register %0h", a), mdl[a], rdv)
  endtask

  task automatic wait_valid(input logic lvl, output int t);
    int n;
    n = 0;
    while (o_ring_valid !== lvl && n < 20000) begin
      @(posedge i_sys_clk);
      #1 n++;
    end
    t = cyc;
  endtask

  // Ring with legal cadence until valid, then silence until the ring ends
  task automatic ring_run(input int c, input int d, input int t);
    int tv;
    int te;
    int ev;
    int ee;
    wm(REG_CTRL2, {d[2], t[3:0], c[2:0]});
    wm(REG_CTRL3, 8'h8A);
    @(posedge i_sys_clk);
    i_delay_lo <= d[1:0];
    gap <= 16'(28 + $unsigned($random(seed)) % 21);
    go <= 1'b1;
    @(posedge ring_event);
    first_ev = cyc;
    wait_valid(1'b1, tv);
    ev = (conf_ms[c] / 2 + 128 * d) * TCK + 5;
    `CHK("valid latency", 1'b1, ((tv - first_ev - ev) inside {[-TOL:TOL]}))
    mdl[REG_IRQ_STATUS] = 8'h01;
    mdl[REG_STATE] = 8'h07;
    rc(REG_IRQ_STATUS);
    rc(REG_STATE);
    `CHK("irq on valid", 1'b1, o_irq)
    @(posedge i_sys_clk);
    go <= 1'b0;
    wait_valid(1'b0, te);
    ee = ((t == 0) ? 40 : 64 * t) * TCK + 4;
    `CHK("timeout", 1'b1, ((te - last_ev - ee) inside {[-TOL:TOL]}))
    mdl[REG_IRQ_STATUS] = 8'h05;
    mdl[REG_STATE] = 8'h00;
    rc(REG_IRQ_STATUS);
    wm(REG_IRQ_CLEAR, 8'h07);
    rc(REG_IRQ_STATUS);
    `CHK("irq cleared", 1'b0, o_irq)
  endtask

  initial begin
    mdl = '{default: 8'h00};
    mdl[REG_CTRL2] = CTRL2_RESET;
    mdl[REG_CTRL3] = CTRL3_RESET;
    repeat (4) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    // Reset values, read-only and unmapped places, random control values
    rc(REG_CTRL2);
    rc(REG_CTRL3);
    rc(REG_IRQ_STATUS);
    rc(REG_IRQ_CLEAR);
    rc(REG_IRQ_ENABLE);
    rc(REG_STATE);
    rc(8'h40);
    wm(REG_IRQ_STATUS, 8'hFF);
    wm(REG_STATE, 8'hFF);
    rc(REG_IRQ_STATUS);
    rc(REG_STATE);
    repeat (4) begin
      wm(REG_CTRL2, 8'($random(seed)));
      rc(REG_CTRL2);
      wm(REG_CTRL3, 8'($random(seed)) & 8'h7F);
      rc(REG_CTRL3);
    end
    $display("test registers done");
    // Validation off: events must leave no trace
    wm(REG_CTRL3, 8'h0A);
    @(posedge i_sys_clk);
    go <= 1'b1;
    repeat (600) @(posedge i_sys_clk);
    `CHK("valid while off", 1'b0, o_ring_valid)
    rc(REG_STATE);
    rc(REG_IRQ_STATUS);
    $display("test disabled done");
    // Crossings every 3 ticks against a 5 tick least spacing
    wm(REG_CTRL3, 8'h8A);
    @(posedge i_sys_clk);
    gap <= 16'h000C;
    repeat (300) @(posedge i_sys_clk);
    `CHK("valid on fast ring", 1'b0, o_ring_valid)
    mdl[REG_IRQ_STATUS] = 8'h02;
    rc(REG_IRQ_STATUS);
    `CHK("masked irq", 1'b0, o_irq)
    wm(REG_IRQ_ENABLE, 8'h02);
    @(posedge i_sys_clk);
    #1 `CHK("enabled irq", 1'b1, o_irq)
    // Disable first so a half-confirmed ring cannot run on to valid
    wm(REG_CTRL3, 8'h0A);
    go <= 1'b0;
    repeat (200) @(posedge i_sys_clk);
    wm(REG_IRQ_CLEAR, 8'h02);
    rc(REG_IRQ_STATUS);
    `CHK("irq after clear", 1'b0, o_irq)
    wm(REG_IRQ_ENABLE, 8'h07);
    $display("test fast ring done");
    // Every confirm, timeout and delay code
    for (int i = 0; i < 16; i++) begin
      ring_run(i % 8, (i < 8) ? i : 0, i);
    end
    $display("test codes done");
    // Clearing the enable in the valid state drops the indication
    wm(REG_CTRL2, 8'h00);
    @(posedge i_sys_clk);
    i_delay_lo <= 2'h0;
    go <= 1'b1;
    wait_valid(1'b1, first_ev);
    wm(REG_CTRL3, 8'h0A);
    repeat (4) @(posedge i_sys_clk);
    #1 `CHK("valid after off", 1'b0, o_ring_valid)
    mdl[REG_STATE] = 8'h00;
    rc(REG_STATE);
    @(posedge i_sys_clk);
    go <= 1'b0;
    $display("test disable in ring done");
    summarize();
  end
endmodule
`default_nettype wire
